// ---- rrs_exec.sv ----
// executor for return-with-literal, return, rotate through carry and sleep
// assumes an APB master on pclk; core logic outside reads fetch_halt and wakes via register
//
// Operation
// - return_with_literal loads its 8-bit literal into the accumulator, flags kept
// - return_with_literal pops stack_top into the program counter
// - return_with_literal is one word and takes two instruction cycles
// - plain return pops stack_top into the program counter in two cycles, flags kept
// - rotate_left_via_carry shifts toward bit 7, touching only carry
// - rotate_left_via_carry destination bit 0 goes to accumulator, 1 to register
// - rotate_right_via_carry shifts the register toward bit 0 through carry
// - rotate_right_via_carry destination bit 0 goes to accumulator, 1 to register
// - sleep clears watchdog_counter and its prescaler
// - sleep clears powerdown_flag
// - sleep sets timeout_flag
//
// Our own choices: register access over APB and the register addresses.
`include "rrs_map.svh"
module rrs_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic fetch_halt
);
  rrs_pkg::rrs_state_e state_ff, nxt_state;
  logic [15:0] instr_ff;
  logic [7:0] acc_ff, nxt_acc;
  logic [7:0] freg_ff, nxt_freg;
  logic carry_ff, nxt_carry;
  logic pdown_ff, nxt_pdown;
  logic tout_ff, nxt_tout;
  rrs_pkg::rrs_addr_t pc_ff, nxt_pc;
  logic [7:0] wdog_ff, wpre_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff, fetch_halt_ff;

  // rotate through carry: result in [7:0], new carry in [8]
  function automatic logic [8:0] rrs_rotate(input logic left, input logic [7:0] v,
                                            input logic c);
    rrs_rotate = left ? {v[7], v[6:0], c} : {v[0], c, v[7:1]};
  endfunction : rrs_rotate

  function automatic logic rrs_hit(input logic [7:0] a, input logic [7:0] off);
    rrs_hit = (a == off);
  endfunction : rrs_hit

  // bus decode
  wire logic setup_ph = psel & ~penable;
  wire logic access_ok = psel & penable & pready_ff;
  wire logic hit_instr = rrs_hit(paddr, `RRS_OFF_INSTR);
  wire logic hit_acc = rrs_hit(paddr, `RRS_OFF_ACC);
  wire logic hit_status = rrs_hit(paddr, `RRS_OFF_STATUS);
  wire logic hit_freg = rrs_hit(paddr, `RRS_OFF_FREG);
  wire logic hit_pc = rrs_hit(paddr, `RRS_OFF_PC);
  wire logic hit_stack = rrs_hit(paddr, `RRS_OFF_STACK);
  wire logic hit_wdog = rrs_hit(paddr, `RRS_OFF_WDOG);
  wire logic hit_wake = rrs_hit(paddr, `RRS_OFF_WAKE);
  wire logic mapped = hit_instr | hit_acc | hit_status | hit_freg | hit_pc | hit_stack
                      | hit_wdog | hit_wake;
  wire logic wr_ok = access_ok & pwrite & ~pslverr_ff;
  wire logic idle = (state_ff == rrs_pkg::RRS_IDLE);
  // state writes are refused while an instruction is in flight, so execution owns them
  wire logic sw_wr = wr_ok & idle;

  // decoded instruction
  wire rrs_pkg::rrs_op_e op = rrs_pkg::rrs_op_e'(instr_ff[`RRS_INSTR_OP_HI:`RRS_INSTR_OP_LO]);
  wire logic dest_reg = instr_ff[`RRS_INSTR_DEST];
  wire logic [7:0] lit = instr_ff[`RRS_INSTR_LIT_HI:0];
  wire logic exec1 = (state_ff == rrs_pkg::RRS_EXEC1);
  wire logic is_ret = (op == rrs_pkg::RRS_OP_RETLIT) || (op == rrs_pkg::RRS_OP_RETURN);
  wire logic is_rot = (op == rrs_pkg::RRS_OP_ROTL) || (op == rrs_pkg::RRS_OP_ROTR);
  wire logic is_sleep = (op == rrs_pkg::RRS_OP_SLEEP);
  wire logic [8:0] rot_res = rrs_rotate(op == rrs_pkg::RRS_OP_ROTL, freg_ff, carry_ff);
  wire logic do_pop = exec1 & is_ret;
  wire logic do_push = sw_wr & hit_stack;
  wire logic wake = wr_ok & hit_wake & pwdata[`RRS_WAKE_BIT];
  wire logic wdog_clr = exec1 & is_sleep;

  rrs_pkg::rrs_addr_t stk_top;
  logic [3:0] stk_depth;

  rrs_stack u_stack (
    .clk(pclk),
    .rst_n(presetn),
    .push(do_push),
    .pop(do_pop),
    .push_data(pwdata[15:0]),
    .top(stk_top),
    .depth(stk_depth)
  );

  wire logic [7:0] status_rd = {3'h0, ~idle & (state_ff == rrs_pkg::RRS_SLEEP), ~idle,
                                tout_ff, pdown_ff, carry_ff};
  wire logic [31:0] rd_mux = hit_instr ? {16'h0000, instr_ff} :
                             hit_acc ? {24'h00_0000, acc_ff} :
                             hit_status ? {24'h00_0000, status_rd} :
                             hit_freg ? {24'h00_0000, freg_ff} :
                             hit_pc ? {16'h0000, pc_ff} :
                             hit_stack ? {12'h000, stk_depth, stk_top} :
                             hit_wdog ? {16'h0000, wpre_ff, wdog_ff} : 32'h0000_0000;

  always_comb begin
    nxt_state = state_ff;
    nxt_acc = acc_ff;
    nxt_freg = freg_ff;
    nxt_carry = carry_ff;
    nxt_pdown = pdown_ff;
    nxt_tout = tout_ff;
    nxt_pc = pc_ff;
    if (sw_wr & hit_acc) begin
      nxt_acc = pwdata[7:0];
    end
    if (sw_wr & hit_freg) begin
      nxt_freg = pwdata[7:0];
    end
    if (sw_wr & hit_status) begin
      nxt_carry = pwdata[`RRS_ST_CARRY];
    end
    if (sw_wr & hit_pc) begin
      nxt_pc = pwdata[15:0];
    end
    unique case (state_ff)
      rrs_pkg::RRS_IDLE: begin
        if (wr_ok & hit_instr) begin
          nxt_state = rrs_pkg::RRS_EXEC1;
        end
      end
      rrs_pkg::RRS_EXEC1: begin
        nxt_state = rrs_pkg::RRS_IDLE;
        if (is_ret) begin
          nxt_pc = stk_top;
          nxt_state = rrs_pkg::RRS_EXEC2;
        end
        if (op == rrs_pkg::RRS_OP_RETLIT) begin
          nxt_acc = lit;
        end
        if (is_rot) begin
          nxt_carry = rot_res[8];
          if (dest_reg) begin
            nxt_freg = rot_res[7:0];
          end else begin
            nxt_acc = rot_res[7:0];
          end
        end
        if (is_sleep) begin
          nxt_pdown = 1'b0;
          nxt_tout = 1'b1;
          nxt_state = rrs_pkg::RRS_SLEEP;
        end
      end
      // the extra cycle only absorbs the branch; nothing else changes
      rrs_pkg::RRS_EXEC2: begin
        nxt_state = rrs_pkg::RRS_IDLE;
      end
      rrs_pkg::RRS_SLEEP: begin
        if (wake) begin
          nxt_state = rrs_pkg::RRS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= rrs_pkg::RRS_IDLE;
      acc_ff <= `RRS_RST_ACC;
      freg_ff <= `RRS_RST_FREG;
      carry_ff <= 1'b0;
      pdown_ff <= `RRS_RST_PDOWN;
      tout_ff <= `RRS_RST_TOUT;
      pc_ff <= `RRS_RST_PC;
      fetch_halt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      acc_ff <= nxt_acc;
      freg_ff <= nxt_freg;
      carry_ff <= nxt_carry;
      pdown_ff <= nxt_pdown;
      tout_ff <= nxt_tout;
      pc_ff <= nxt_pc;
      fetch_halt_ff <= (nxt_state == rrs_pkg::RRS_SLEEP);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_ff <= `RRS_RST_INSTR;
    end else if (wr_ok & hit_instr & idle) begin
      instr_ff <= pwdata[15:0];
    end
  end

  // watchdog keeps running while asleep; only sleep entry restarts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wpre_ff <= 8'h00;
      wdog_ff <= 8'h00;
    end else if (wdog_clr) begin
      wpre_ff <= 8'h00;
      wdog_ff <= 8'h00;
    end else if (wpre_ff == `RRS_WDOG_PRE_MAX) begin
      wpre_ff <= 8'h00;
      wdog_ff <= wdog_ff + 8'h01;
    end else begin
      wpre_ff <= wpre_ff + 8'h01;
    end
  end

  // answer is registered: ready rises in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_ph;
      pslverr_ff <= setup_ph & ~mapped;
      if (setup_ph) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign fetch_halt = fetch_halt_ff;

  AST_RETLIT_ACC: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_RETLIT |=> acc_ff == $past(lit) && carry_ff == $past(carry_ff))
    else $error("literal not loaded or carry disturbed");

  AST_RET_PC: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && is_ret |=> pc_ff == $past(stk_top) && stk_depth != $past(stk_depth) ||
      $past(stk_depth) == 4'h0)
    else $error("return did not load pc from popped stack top");

  AST_RET_TWO_CYCLES: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ok && hit_instr && idle && pwdata[15:12] == 4'h1
      |=> exec1 ##1 state_ff == rrs_pkg::RRS_EXEC2 ##1 idle)
    else $error("return with literal did not take two cycles");

  AST_RETURN_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_RETURN |=> $stable(carry_ff) && $stable(acc_ff)
      && $stable(pdown_ff) && $stable(tout_ff) ##1 idle)
    else $error("plain return touched state or overran");

  AST_ROTL: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTL |=> carry_ff == $past(freg_ff[7])
      && $stable(pdown_ff) && $stable(tout_ff))
    else $error("rotate left carry wrong");

  AST_ROTL_DEST: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTL && !dest_reg
      |=> acc_ff == {$past(freg_ff[6:0]), $past(carry_ff)} && $stable(freg_ff))
    else $error("rotate left to accumulator wrong");

  AST_ROTR: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTR |=> carry_ff == $past(freg_ff[0]))
    else $error("rotate right carry wrong");

  AST_ROTR_DEST: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTR && dest_reg
      |=> freg_ff == {$past(carry_ff), $past(freg_ff[7:1])} && $stable(acc_ff))
    else $error("rotate right to register wrong");

  AST_SLEEP_WDOG: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_clr |=> wdog_ff == 8'h00 && wpre_ff == 8'h00 ##1 wpre_ff == 8'h01)
    else $error("watchdog not cleared by sleep");

  AST_SLEEP_PDOWN: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_clr |=> !pdown_ff)
    else $error("powerdown flag not cleared");

  AST_SLEEP_TOUT: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_clr |=> tout_ff)
    else $error("timeout flag not set");

  AST_ROT_FILL: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTR && !dest_reg |=> acc_ff[7] == $past(carry_ff))
    else $error("old carry did not enter bit 7");

  AST_SLEEP_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    wdog_clr |=> fetch_halt_ff && state_ff == rrs_pkg::RRS_SLEEP)
    else $error("fetch not halted after sleep");

  // a wake may come any cycle after entry, so holding is checked cycle by cycle
  AST_HALT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == rrs_pkg::RRS_SLEEP && !wake
      |=> fetch_halt_ff && state_ff == rrs_pkg::RRS_SLEEP)
    else $error("fetch halt dropped without a wake");

  AST_ROTL_REG: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTL && dest_reg
      |=> freg_ff == {$past(freg_ff[6:0]), $past(carry_ff)} && $stable(acc_ff))
    else $error("rotate left to register wrong");

  AST_ROTR_ACC: assert property (@(posedge pclk) disable iff (!presetn)
    exec1 && op == rrs_pkg::RRS_OP_ROTR && !dest_reg
      |=> acc_ff == {$past(carry_ff), $past(freg_ff[7:1])} && $stable(freg_ff))
    else $error("rotate right to accumulator wrong");
endmodule : rrs_exec

// ---- rrs_map.svh ----
// register offsets, field positions and reset values of the return/rotate/sleep executor
// assumes a 32-bit APB slave with byte addresses, each register one aligned word
`ifndef RRS_MAP_SVH
`define RRS_MAP_SVH
`define RRS_OFF_INSTR 8'h00
`define RRS_OFF_ACC 8'h04
`define RRS_OFF_STATUS 8'h08
`define RRS_OFF_FREG 8'h0C
`define RRS_OFF_PC 8'h10
`define RRS_OFF_STACK 8'h14
`define RRS_OFF_WDOG 8'h18
`define RRS_OFF_WAKE 8'h1C
`define RRS_INSTR_OP_HI 15
`define RRS_INSTR_OP_LO 12
`define RRS_INSTR_DEST 8
`define RRS_INSTR_LIT_HI 7
`define RRS_ST_CARRY 0
`define RRS_ST_PDOWN 1
`define RRS_ST_TOUT 2
`define RRS_ST_BUSY 3
`define RRS_ST_ASLEEP 4
`define RRS_WAKE_BIT 0
`define RRS_RST_ACC 8'h00
`define RRS_RST_FREG 8'h00
`define RRS_RST_PC 16'h0000
`define RRS_RST_INSTR 16'h0000
`define RRS_RST_PDOWN 1'b1
`define RRS_RST_TOUT 1'b1
`define RRS_WDOG_PRE_MAX 8'hFF
`define RRS_STACK_DEPTH 8
`define RRS_STACK_PTR_W 3
`endif

// ---- rrs_pkg.sv ----
// types shared by the executor and its stack
// assumes rrs_map.svh provides the numeric constants
package rrs_pkg;
  typedef enum logic [1:0] {
    RRS_IDLE = 2'b00,
    RRS_EXEC1 = 2'b01,
    RRS_EXEC2 = 2'b10,
    RRS_SLEEP = 2'b11
  } rrs_state_e;
  typedef enum logic [3:0] {
    RRS_OP_NOP = 4'h0,
    RRS_OP_RETLIT = 4'h1,
    RRS_OP_RETURN = 4'h2,
    RRS_OP_ROTL = 4'h3,
    RRS_OP_ROTR = 4'h4,
    RRS_OP_SLEEP = 4'h5
  } rrs_op_e;
  typedef logic [15:0] rrs_addr_t;
endpackage : rrs_pkg

// ---- rrs_stack.sv ----
// circular return-address stack for the executor
// assumes push and pop never arrive in the same cycle; overflow overwrites the oldest entry
`include "rrs_map.svh"
module rrs_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic push,
  input wire logic pop,
  input wire rrs_pkg::rrs_addr_t push_data,
  output rrs_pkg::rrs_addr_t top,
  output logic [3:0] depth
);
  rrs_pkg::rrs_addr_t mem [`RRS_STACK_DEPTH];
  logic [`RRS_STACK_PTR_W-1:0] ptr_ff;
  logic [3:0] cnt_ff;
  wire logic [`RRS_STACK_PTR_W-1:0] top_idx = ptr_ff - 3'h1;
  wire logic cnt_full = (cnt_ff == 4'(`RRS_STACK_DEPTH));

  assign top = mem[top_idx];
  assign depth = cnt_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[ptr_ff] <= push_data;
    end
  end

  // popping an empty stack still moves the pointer, like the real wraparound
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_ff <= 3'h0;
      cnt_ff <= 4'h0;
    end else if (push) begin
      ptr_ff <= ptr_ff + 3'h1;
      cnt_ff <= cnt_full ? cnt_ff : cnt_ff + 4'h1;
    end else if (pop) begin
      ptr_ff <= top_idx;
      cnt_ff <= (cnt_ff == 4'h0) ? cnt_ff : cnt_ff - 4'h1;
    end
  end
endmodule : rrs_stack

// ---- tb_return_rotate_sleep_exec.sv ----
// self-checking bench for the return/rotate/sleep executor over APB
// assumes rrs_map.svh offsets and rrs_pkg opcodes; bench drives every port itself
`include "rrs_map.svh"
module tb_return_rotate_sleep_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fetch_halt;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rnd = 32'hf0fa;
  logic [31:0] rd;
  logic er;
  logic [7:0] acc;
  logic [7:0] freg;
  logic [7:0] res;
  logic car;
  logic exp_pdown = 1'b1;
  logic exp_tout = 1'b1;
  logic [15:0] pc;
  logic [15:0] stk[$];

  always #12.5 pclk = ~pclk;

  rrs_exec DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .fetch_halt(fetch_halt)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench cycle ceiling ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdchk

  // busy reads high for the whole of a sleep
  task automatic stchk(input logic slp);
    apb(1'b0, `RRS_OFF_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_001F, {27'h000_0000, slp, slp, exp_tout, exp_pdown, car});
  endtask : stchk

  // poll until idle, or until asleep: a sleep never reports idle
  task automatic exec(input logic [3:0] op, input logic d, input logic [7:0] k);
    apb(1'b1, `RRS_OFF_INSTR, {16'h0000, op, 3'h0, d, k});
    do begin
      apb(1'b0, `RRS_OFF_STATUS, 32'h0000_0000);
    end while (rd[3] !== 1'b0 && rd[4] !== 1'b1);
  endtask : exec

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    car = 1'b0;
    chk({29'h0000_0000, pready, pslverr, fetch_halt}, 32'h0000_0000);
    rdchk(`RRS_OFF_ACC, 32'h0000_0000);
    rdchk(`RRS_OFF_FREG, 32'h0000_0000);
    rdchk(`RRS_OFF_PC, 32'h0000_0000);
    stchk(1'b0);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    $display("test reset and unmapped done");
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      apb(1'b1, `RRS_OFF_STACK, {16'h0000, rnd[15:0]});
      stk.push_back(rnd[15:0]);
    end
    rnd = lfsr(rnd);
    car = rnd[0];
    apb(1'b1, `RRS_OFF_STATUS, {31'h0000_0000, car});
    for (int i = 0; i < 2; i++) begin
      rnd = lfsr(rnd);
      exec(rrs_pkg::RRS_OP_RETLIT, 1'b0, rnd[7:0]);
      acc = rnd[7:0];
      pc = stk.pop_back();
      rdchk(`RRS_OFF_ACC, {24'h00_0000, acc});
      rdchk(`RRS_OFF_PC, {16'h0000, pc});
      stchk(1'b0);
    end
    exec(rrs_pkg::RRS_OP_RETURN, 1'b0, 8'h5A);
    pc = stk.pop_back();
    rdchk(`RRS_OFF_PC, {16'h0000, pc});
    rdchk(`RRS_OFF_ACC, {24'h00_0000, acc});
    stchk(1'b0);
    rdchk(`RRS_OFF_STACK, {12'h000, 4'h1, stk[0]});
    $display("test returns done");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      freg = rnd[7:0];
      acc = rnd[23:16];
      car = rnd[8];
      apb(1'b1, `RRS_OFF_FREG, {24'h00_0000, freg});
      apb(1'b1, `RRS_OFF_ACC, {24'h00_0000, acc});
      apb(1'b1, `RRS_OFF_STATUS, {31'h0000_0000, car});
      res = i[0] ? {car, freg[7:1]} : {freg[6:0], car};
      exec(i[0] ? rrs_pkg::RRS_OP_ROTR : rrs_pkg::RRS_OP_ROTL, i[1], rnd[31:24]);
      car = i[0] ? freg[0] : freg[7];
      if (i[1]) begin
        freg = res;
      end else begin
        acc = res;
      end
      rdchk(`RRS_OFF_ACC, {24'h00_0000, acc});
      rdchk(`RRS_OFF_FREG, {24'h00_0000, freg});
      stchk(1'b0);
    end
    $display("test rotates done");
    exec(rrs_pkg::RRS_OP_SLEEP, 1'b0, 8'h00);
    exp_pdown = 1'b0;
    exp_tout = 1'b1;
    chk({31'h0000_0000, fetch_halt}, 32'h0000_0001);
    stchk(1'b1);
    apb(1'b0, `RRS_OFF_WDOG, 32'h0000_0000);
    chk({24'h00_0000, rd[7:0]}, 32'h0000_0000);
    // prescaler restarted at sleep, so only a short run since then
    chk({31'h0000_0000, rd[15:8] < 8'h80}, 32'h0000_0001);
    apb(1'b1, `RRS_OFF_INSTR, {16'h0000, 4'h1, 4'h0, 8'h3C});
    apb(1'b1, `RRS_OFF_WAKE, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk({31'h0000_0000, fetch_halt}, 32'h0000_0000);
    rdchk(`RRS_OFF_ACC, {24'h00_0000, acc});
    stchk(1'b0);
    $display("test sleep and wake done");
    summarize();
  end
endmodule : tb_return_rotate_sleep_exec
